// ---- stpg_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - Port 3 is the processor port; gating acts on ports 1 and 2.
// - Ports 1 and 2 each hold transmit, receive and learning-disable bits.
// - Disabled setting: no ordinary traffic either way, no learning.
// - Override frames still reach the processor with enables cleared.
// - Blocking: only override frames to the processor and processor-directed frames pass; no learning.
// - Processor-directed frames leave a network port with transmit off.
// - Learning setting: processor traffic only, while source learning runs.
// - Forwarding setting: all traffic passes and addresses are learned.
// - Learning disable set stops learning from that port.
// - Flush bits in control register 2 clear the port's table entries.
// - Discarding uses the disabled setting and covers three STP states.
// - Tail tag low bits pick destination; egress bit 0 gives source.
// - Tail tagging acts only while bit 6 of register 3 is set.
module stpg_top
  import stpg_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [STPG_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic I_VALID,
  output logic I_READY,
  input wire logic [DW-1:0] I_DATA,
  input wire logic I_LAST,
  input wire logic [1:0] I_SRC,
  input wire logic [2:0] I_DMASK,
  input wire logic I_OVR,
  input wire logic [1:0] I_TAG,
  output logic O_VALID,
  input wire logic O_READY,
  output logic [DW-1:0] O_DATA,
  output logic O_LAST,
  output logic [2:0] O_MASK,
  output logic [7:0] O_TAG,
  output logic O_LEARN,
  output logic [1:0] O_LEARN_PORT,
  output logic [1:0] O_FLUSH,
  output logic [5:0] O_PORT_STATE
);

  localparam int BW = DW + 12;

  stpg_top_type r, n;
  logic hdr, take, push;
  logic [2:0] hmask, fmask;
  logic [7:0] htag, ftag;
  logic [2:0] sctl;
  logic [BW-1:0] bout;

  // Refuse a data width the gate cannot carry
  if (DW < 1) begin : g_dw_chk
    $error("stpg_top data width must be positive");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Drop network destinations whose transmit enable is clear
  function automatic logic [2:0] gate_tx(input logic [2:0] m,
                                         input logic [2:0] c1,
                                         input logic [2:0] c2);
    gate_tx = {m[2], m[1] & c2[STPG_TXEN_BIT], m[0] & c1[STPG_TXEN_BIT]};
  endfunction

  // Register index from the byte address, or all ones if misaligned
  function automatic logic [7:0] reg_idx(input logic [STPG_ADDR_W-1:0] a);
    reg_idx = (a[1:0] != 2'h0) ? 8'hFF : a[9:2];
  endfunction

  // Read value of one register
  function automatic logic [31:0] rd_val(input logic [7:0] idx,
                                         input stpg_top_type s);
    unique case (idx)
      STPG_IDX_GCTRL2: rd_val = 32'h0;
      STPG_IDX_GCTRL3: rd_val = 32'(s.tail) << STPG_TAIL_BIT;
      STPG_IDX_P1CTRL: rd_val = {29'h0, s.c1};
      STPG_IDX_P2CTRL: rd_val = {29'h0, s.c2};
      STPG_IDX_STATUS: rd_val = {24'h0, s.drop, s.in_frame, s.a2, s.a1};
      default: rd_val = 32'h0;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] idx);
    reg_hit = idx == STPG_IDX_GCTRL2 || idx == STPG_IDX_GCTRL3 ||
              idx == STPG_IDX_P1CTRL || idx == STPG_IDX_P2CTRL ||
              idx == STPG_IDX_STATUS;
  endfunction

  // ----------------------------------------------------------------
  // Frame decision at the first word
  // ----------------------------------------------------------------

  assign hdr = !r.in_frame;
  assign sctl = (I_SRC == STPG_SRC_P2) ? r.a2 : r.a1;

  // Destination mask per source port and applied controls
  always_comb begin
    hmask = 3'h0;
    htag = 8'h0;
    if (I_SRC == STPG_SRC_CPU) begin
      if (r.tail && I_TAG != 2'h0) begin
        hmask = {1'b0, I_TAG};
      end else begin
        hmask = gate_tx(I_DMASK, r.a1, r.a2) & STPG_M_NET;
      end
    end else if (I_SRC == STPG_SRC_P1 || I_SRC == STPG_SRC_P2) begin
      if (sctl[STPG_RXEN_BIT]) begin
        hmask = gate_tx(I_DMASK, r.a1, r.a2) & ~{1'b0, I_SRC};
      end else if (I_OVR) begin
        hmask = STPG_M_CPU;
      end
      if (r.tail && hmask[2]) begin
        htag = {7'h0, I_SRC == STPG_SRC_P2};
      end
    end
  end

  assign take = I_VALID && I_READY;
  assign fmask = hdr ? hmask : r.mask;
  assign ftag = hdr ? htag : r.tag;
  assign push = I_VALID && fmask != 3'h0 && !(r.drop && !hdr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.learn = 1'b0;
    n.flush = 2'h0;
    if (!r.in_frame) begin
      n.a1 = r.c1;
      n.a2 = r.c2;
    end
    // Frame tracking and learning
    if (take) begin
      n.in_frame = !I_LAST;
      if (hdr) begin
        n.mask = hmask;
        n.tag = htag;
        n.drop = hmask == 3'h0;
        if (I_SRC != STPG_SRC_CPU && I_SRC != 2'h0 &&
            !sctl[STPG_LDIS_BIT]) begin
          n.learn = 1'b1;
          n.lport = I_SRC;
        end
      end
    end
    // APB setup phase prepares the answer
    if (PSEL && !PENABLE) begin
      n.pready = 1'b1;
      n.prdata = rd_val(reg_idx(PADDR), r);
      n.pslverr = !reg_hit(reg_idx(PADDR));
    end else if (PSEL && PENABLE && r.pready) begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (PWRITE && reg_hit(reg_idx(PADDR))) begin
        unique case (reg_idx(PADDR))
          STPG_IDX_GCTRL2: begin
            n.flush = {PWDATA[STPG_FLUSH_P2_BIT], PWDATA[STPG_FLUSH_P1_BIT]};
          end
          STPG_IDX_GCTRL3: begin
            n.tail = PWDATA[STPG_TAIL_BIT];
          end
          STPG_IDX_P1CTRL: begin
            n.c1 = PWDATA[2:0];
          end
          STPG_IDX_P2CTRL: begin
            n.c2 = PWDATA[2:0];
          end
          default: begin
            n.tail = r.tail;
          end
        endcase
      end
    end else begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      r <= '0;
      r.c1 <= STPG_PCTRL_RST;
      r.c2 <= STPG_PCTRL_RST;
      r.a1 <= STPG_PCTRL_RST;
      r.a2 <= STPG_PCTRL_RST;
      r.tail <= STPG_TAIL_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  stpg_buf #(.W(BW)) u_buf (
    .clk(CLK),
    .rst(RST),
    .in_valid(push),
    .in_ready(I_READY),
    .in_data({I_DATA, I_LAST, fmask, ftag}),
    .out_valid(O_VALID),
    .out_ready(O_READY),
    .out_data(bout)
  );

  assign O_DATA = bout[BW-1:12];
  assign O_LAST = bout[11];
  assign O_MASK = bout[10:8];
  assign O_TAG = bout[7:0];
  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign O_LEARN = r.learn;
  assign O_LEARN_PORT = r.lport;
  assign O_FLUSH = r.flush;
  assign O_PORT_STATE = {r.a2, r.a1};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_hdr_take;
    take && hdr;
  endsequence

  // Register write at the access edge
  sequence s_apb_wr;
    PSEL && PENABLE && PREADY && PWRITE;
  endsequence

  a_blocked_rx_cpu: assert property (
    s_hdr_take ##0 (I_SRC == STPG_SRC_P1 && !r.a1[STPG_RXEN_BIT])
    |-> (push ? hmask == STPG_M_CPU && I_OVR : !I_OVR))
    else $error("blocked port frame went past processor");
  a_override_cpu: assert property (
    s_hdr_take ##0 (I_SRC == STPG_SRC_P2 && I_OVR) |-> hmask[2] ||
    r.a2[STPG_RXEN_BIT]) else $error("override frame lost");
  a_learn_gate: assert property (
    s_hdr_take ##0 (I_SRC == STPG_SRC_P1) |=>
    O_LEARN == !$past(r.a1[STPG_LDIS_BIT]))
    else $error("learning did not follow disable bit");
  a_learn_port: assert property (
    s_hdr_take ##0 (I_SRC == STPG_SRC_P2 && !r.a2[STPG_LDIS_BIT])
    |=> O_LEARN && O_LEARN_PORT == 2'h2) else $error("learn port wrong");
  a_fwd_pass: assert property (
    s_hdr_take ##0 (I_SRC == STPG_SRC_P2 && r.a2 == 3'h6 &&
    I_DMASK == STPG_M_CPU) |-> push && hmask == STPG_M_CPU)
    else $error("forwarding port frame not passed");
  a_ctrl_write: assert property (
    s_apb_wr ##0 (PADDR == {STPG_IDX_P1CTRL, 2'h0})
    |=> r.c1 == $past(PWDATA[2:0])) else $error("port control not written");
  a_flush_write: assert property (
    s_apb_wr ##0 (PADDR == {STPG_IDX_GCTRL2, 2'h0}) |=>
    O_FLUSH[0] == $past(PWDATA[STPG_FLUSH_P1_BIT]) &&
    O_FLUSH[1] == $past(PWDATA[STPG_FLUSH_P2_BIT]))
    else $error("flush pulse does not match write");
  a_no_learn_dis: assert property (
    s_hdr_take ##0 (I_SRC == STPG_SRC_P2 && r.a2[STPG_LDIS_BIT])
    |=> !O_LEARN) else $error("learned on disabled port");
  a_tx_gate_net: assert property (
    s_hdr_take ##0 (I_SRC == STPG_SRC_P1 && !r.a2[STPG_TXEN_BIT])
    |-> !hmask[1]) else $error("sent to transmit-disabled port");
  a_cpu_directed: assert property (
    s_hdr_take ##0 (I_SRC == STPG_SRC_CPU && r.tail && I_TAG == 2'h2)
    |-> hmask == 3'h2) else $error("directed frame not sent");
  a_tail_off: assert property (
    !r.tail && push |-> ftag == 8'h0) else $error("tag while tail off");
  a_apply_hold: assert property (
    r.in_frame && $past(r.in_frame) |-> $stable(r.a1) && $stable(r.a2))
    else $error("control changed inside frame");
  a_flush_pulse: assert property (
    O_FLUSH != 2'h0 |=> O_FLUSH == 2'h0) else $error("flush not a pulse");
  a_apb_ready: assert property (
    PSEL && !PENABLE ##1 PSEL && PENABLE |-> PREADY ##1 !PREADY)
    else $error("apb answer timing wrong");

endmodule

// ---- stpg_pkg.sv ----
package stpg_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] STPG_IDX_GCTRL2 = 8'h02;
  localparam logic [7:0] STPG_IDX_GCTRL3 = 8'h03;
  localparam logic [7:0] STPG_IDX_P1CTRL = 8'h12;
  localparam logic [7:0] STPG_IDX_P2CTRL = 8'h22;
  localparam logic [7:0] STPG_IDX_STATUS = 8'h3C;
  localparam int STPG_ADDR_W = 10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STPG_FLUSH_P1_BIT = 4;
  localparam int STPG_FLUSH_P2_BIT = 5;
  localparam int STPG_TAIL_BIT = 6;
  localparam int STPG_LDIS_BIT = 0;
  localparam int STPG_RXEN_BIT = 1;
  localparam int STPG_TXEN_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values and port codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STPG_PCTRL_RST = 3'h6;
  localparam logic STPG_TAIL_RST = 1'b0;
  localparam logic [1:0] STPG_SRC_P1 = 2'h1;
  localparam logic [1:0] STPG_SRC_P2 = 2'h2;
  localparam logic [1:0] STPG_SRC_CPU = 2'h3;
  localparam logic [2:0] STPG_M_CPU = 3'h4;
  localparam logic [2:0] STPG_M_NET = 3'h3;

  // ----------------------------------------------------------------
  // State of the gate
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] c1;
    logic [2:0] c2;
    logic [2:0] a1;
    logic [2:0] a2;
    logic tail;
    logic [1:0] flush;
    logic in_frame;
    logic drop;
    logic [2:0] mask;
    logic [7:0] tag;
    logic learn;
    logic [1:0] lport;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } stpg_top_type;

endpackage

// ---- stpg_buf.sv ----
`timescale 1ns/1ps
module stpg_buf
  import stpg_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  // ----------------------------------------------------------------
  // Two-entry skid buffer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] od;
    logic [W-1:0] sd;
    logic ov;
    logic sv;
    logic rdy;
  } stpg_buf_type;

  stpg_buf_type b_r, b_nxt;
  logic push, pop;

  // Refuse a width the buffer cannot hold
  if (W < 1) begin : g_w_chk
    $error("stpg_buf width must be positive");
  end

  assign push = in_valid & b_r.rdy;
  assign pop = b_r.ov & out_ready;

  // Output slot refills from skid first, then from input
  always_comb begin
    b_nxt = b_r;
    if (!b_r.ov || pop) begin
      if (b_r.sv) begin
        b_nxt.od = b_r.sd;
        b_nxt.ov = 1'b1;
        b_nxt.sv = push;
        b_nxt.sd = push ? in_data : b_r.sd;
      end else begin
        b_nxt.od = push ? in_data : b_r.od;
        b_nxt.ov = push;
      end
    end else if (push) begin
      b_nxt.sd = in_data;
      b_nxt.sv = 1'b1;
    end
    b_nxt.rdy = !b_nxt.sv;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      b_r <= '0;
    end else begin
      b_r <= b_nxt;
    end
  end

  assign in_ready = b_r.rdy;
  assign out_valid = b_r.ov;
  assign out_data = b_r.od;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_buf_no_loss: assert property (b_r.ov && !out_ready |=>
    b_r.ov && $stable(b_r.od)) else $error("buffer output changed stalled");
  a_buf_full_stall: assert property (b_r.sv |-> !b_r.rdy)
    else $error("buffer accepts while full");

endmodule

// ---- stpg_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Processor on port 3: sink of the gated frame stream
// ----------------------------------------------------------------
module stpg_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic valid,
  output logic ready,
  input wire logic last,
  input wire logic [2:0] mask,
  input wire logic [7:0] tag
);
  int n_frames;
  logic first_r;
  logic [2:0] mask_r;
  logic [7:0] tag_r;

  // Ready drops while stalled, so the sink can answer slowly
  assign ready = !stall;

  // frames received
  // Only the header of each frame is kept; payload is thrown away
  always_ff @(posedge clk) begin
    if (rst) begin
      n_frames <= 0;
      first_r <= 1'h1;
    end else if (valid && ready) begin
      if (first_r) begin
        mask_r <= mask;
        tag_r <= tag;
      end
      first_r <= last;
      if (last) begin
        n_frames <= n_frames + 1;
      end
    end
  end
endmodule

// ---- stpg_top_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module stpg_top_test;
  import stpg_pkg::*;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err, stall;
  logic [STPG_ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic I_VALID, I_READY, I_LAST, I_OVR, O_VALID, O_READY, O_LAST, O_LEARN;
  logic [7:0] I_DATA, O_TAG, O_DATA, dq;
  logic [1:0] I_SRC, I_TAG, O_LEARN_PORT, O_FLUSH, lport, fl;
  logic [2:0] I_DMASK, O_MASK;
  logic [5:0] O_PORT_STATE;
  int n_fail, compares, n_learn, nf, nl, n;

  stpg_top #(.DW(8)) dut (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .I_VALID(I_VALID), .I_READY(I_READY), .I_DATA(I_DATA),
    .I_LAST(I_LAST), .I_SRC(I_SRC), .I_DMASK(I_DMASK), .I_OVR(I_OVR),
    .I_TAG(I_TAG), .O_VALID(O_VALID), .O_READY(O_READY), .O_DATA(O_DATA),
    .O_LAST(O_LAST), .O_MASK(O_MASK), .O_TAG(O_TAG), .O_LEARN(O_LEARN),
    .O_LEARN_PORT(O_LEARN_PORT), .O_FLUSH(O_FLUSH),
    .O_PORT_STATE(O_PORT_STATE));
  stpg_host_model sink (.clk(CLK), .rst(RST), .stall(stall),
    .valid(O_VALID), .ready(O_READY), .last(O_LAST), .mask(O_MASK),
    .tag(O_TAG));

  // Clock of 8 ns
  initial begin
    CLK = 1'h0;
    forever #4 CLK = ~CLK;
  end

  // Counts learn pulses and keeps the last flush pulse
  always @(posedge CLK) begin
    if (O_LEARN === 1'h1) begin
      n_learn++;
      lport = O_LEARN_PORT;
    end
    if (O_FLUSH !== 2'h0) fl = O_FLUSH;
    if (O_VALID === 1'h1 && O_READY === 1'h1) dq = O_DATA;
  end

  // ----------------------------------------------------------------
  // Bus and stream tasks
  // ----------------------------------------------------------------
  task stop_test;
    begin
      if (n_fail == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    begin
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'h1;
      i = 0;
      do begin
        @(posedge CLK);
        i++;
      end while (PREADY !== 1'h1 && i < 20);
      if (PREADY !== 1'h1) begin
        n_fail++;
        stop_test;
      end
      q = PRDATA;
      err = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      @(posedge CLK);
    end
  endtask

  task put(input logic [1:0] s, input logic [2:0] m, input logic o,
           input logic [1:0] t, input logic l);
    int i;
    begin
      I_VALID <= 1'h1;
      I_SRC <= s;
      I_DMASK <= m;
      I_OVR <= o;
      I_TAG <= t;
      I_LAST <= l;
      I_DATA <= I_DATA + 8'h1;
      i = 0;
      do begin
        @(posedge CLK);
        i++;
      end while (I_READY !== 1'h1 && i < 20);
      if (I_READY !== 1'h1) begin
        n_fail++;
        stop_test;
      end
    end
  endtask

  // Sends a one-word frame, then checks delivery, header and learning
  task frm(input logic [1:0] s, input logic [2:0] m, input logic o,
           input logic [1:0] t, input int eo, input logic [2:0] em,
           input logic [7:0] et, input int el);
    begin
      nf = sink.n_frames;
      nl = n_learn;
      put(s, m, o, t, 1'h1);
      I_VALID <= 1'h0;
      repeat (6) @(posedge CLK);
      `CHK("frames", nf + eo, sink.n_frames)
      if (eo > 0) begin
        `CHK("mask", em, sink.mask_r)
        `CHK("data", I_DATA, dq)
        `CHK("tag", et, sink.tag_r)
      end
      `CHK("learn", nl + el, n_learn)
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    begin
      `CHK("state", 6'h36, O_PORT_STATE)
      apb(1'h0, 10'h048, 32'h0);
      `CHK("p1", 32'h6, q)
      apb(1'h0, 10'h088, 32'h0);
      `CHK("p2", 32'h6, q)
      apb(1'h0, 10'h0F0, 32'h0);
      `CHK("status", 32'h36, q)
      apb(1'h0, 10'h00C, 32'h0);
      `CHK("tail", 32'h0, q)
      apb(1'h1, 10'h0F4, 32'hFF);
      `CHK("unmapped", 1'h1, err)
      apb(1'h0, 10'h049, 32'h0);
      `CHK("misaligned", 1'h1, err)
    end
  endtask

  task t_gate;
    begin
      frm(2'h1, 3'h6, 1'h0, 2'h0, 1, 3'h6, 8'h0, 1);
      `CHK("lport", 2'h1, lport)
      frm(2'h3, 3'h3, 1'h0, 2'h0, 1, 3'h3, 8'h0, 0);
      apb(1'h1, 10'h048, 32'h1);
      frm(2'h1, 3'h6, 1'h0, 2'h0, 0, 3'h0, 8'h0, 0);
      `CHK("state1", 3'h1, O_PORT_STATE[2:0])
      frm(2'h1, 3'h6, 1'h1, 2'h0, 1, 3'h4, 8'h0, 0);
      frm(2'h2, 3'h1, 1'h0, 2'h0, 0, 3'h0, 8'h0, 1);
      apb(1'h1, 10'h048, 32'h0);
      frm(2'h1, 3'h6, 1'h0, 2'h0, 0, 3'h0, 8'h0, 1);
      frm(2'h1, 3'h6, 1'h1, 2'h0, 1, 3'h4, 8'h0, 1);
      apb(1'h1, 10'h048, 32'h4);
      frm(2'h2, 3'h1, 1'h0, 2'h0, 1, 3'h1, 8'h0, 1);
      `CHK("lport2", 2'h2, lport)
      frm(2'h1, 3'h2, 1'h0, 2'h0, 0, 3'h0, 8'h0, 1);
      apb(1'h1, 10'h048, 32'h0);
      frm(2'h3, 3'h1, 1'h0, 2'h1, 0, 3'h0, 8'h0, 0);
      apb(1'h1, 10'h00C, 32'h40);
      apb(1'h0, 10'h00C, 32'h0);
      `CHK("tail", 32'h40, q)
      frm(2'h3, 3'h0, 1'h0, 2'h1, 1, 3'h1, 8'h0, 0);
      frm(2'h3, 3'h0, 1'h0, 2'h3, 1, 3'h3, 8'h0, 0);
      frm(2'h2, 3'h4, 1'h0, 2'h0, 1, 3'h4, 8'h1, 1);
      frm(2'h1, 3'h4, 1'h1, 2'h0, 1, 3'h4, 8'h0, 1);
      apb(1'h1, 10'h00C, 32'h0);
      apb(1'h1, 10'h048, 32'h6);
    end
  endtask

  task t_flush_mid;
    begin
      fl = 2'h0;
      apb(1'h1, 10'h008, 32'h30);
      @(posedge CLK);
      `CHK("flush", 2'h3, fl)
      fl = 2'h0;
      apb(1'h1, 10'h008, 32'h10);
      @(posedge CLK);
      `CHK("flush", 2'h1, fl)
      apb(1'h0, 10'h008, 32'h0);
      `CHK("reg2", 32'h0, q)
      nf = sink.n_frames;
      put(2'h2, 3'h4, 1'h0, 2'h0, 1'h0);
      I_VALID <= 1'h0;
      apb(1'h1, 10'h088, 32'h1);
      repeat (2) @(posedge CLK);
      `CHK("mid", 3'h6, O_PORT_STATE[5:3])
      put(2'h2, 3'h4, 1'h0, 2'h0, 1'h1);
      I_VALID <= 1'h0;
      repeat (6) @(posedge CLK);
      `CHK("after", 3'h1, O_PORT_STATE[5:3])
      `CHK("frames", nf + 1, sink.n_frames)
      apb(1'h1, 10'h088, 32'h6);
    end
  endtask

  // Stalled sink: input must be refused, and no word may be lost
  task t_stall;
    begin
      nf = sink.n_frames;
      n = 0;
      stall <= 1'h1;
      I_VALID <= 1'h1;
      I_SRC <= 2'h2;
      I_DMASK <= 3'h4;
      I_OVR <= 1'h0;
      I_LAST <= 1'h1;
      repeat (8) begin
        @(posedge CLK);
        if (I_READY === 1'h1) n++;
      end
      I_VALID <= 1'h0;
      `CHK("refused", 1'h0, I_READY)
      @(posedge CLK);
      stall <= 1'h0;
      repeat (10) @(posedge CLK);
      `CHK("drained", nf + n, sink.n_frames)
    end
  endtask

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, stall} = '0;
    {I_VALID, I_DATA, I_LAST, I_SRC, I_DMASK, I_OVR, I_TAG} = '0;
    RST = 1'h1;
    repeat (10) @(posedge CLK);
    RST <= 1'h0;
    repeat (2) @(posedge CLK);
    t_reset;
    t_gate;
    t_flush_mid;
    t_stall;
    stop_test;
  end
endmodule
